// *** pkg/dsick_regs.vh ***
// register offsets, field positions, reset values and code maps of the clock tree
// assumes a 32-bit apb slave with word-aligned registers
//
// Notes on behaviour
// - each root divides by field plus one
// - pixel root select 4 takes second pll
// - select 1 takes crystal on escape, reference
// - transmit escape divides by group field plus one
// - byte clock is one eighth bit clock
// - pll output is ref times M over N*O
// - pll codes are encoded, not binary
// - clock lane toggles once per bit tick, so it runs at half bit rate
// - pixel clock travels with pixel data
// - bridge moves pixels to byte domain, drops
`ifndef DSICK_REGS_VH
`define DSICK_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DSICK_PIX_ROOT_OFS 12'h000
`define DSICK_ESC_ROOT_OFS 12'h004
`define DSICK_REF_ROOT_OFS 12'h008
`define DSICK_ESC_GROUP_OFS 12'h00c
`define DSICK_PLL_OFS 12'h010
`define DSICK_STATUS_OFS 12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DSICK_DIV_LSB 0
`define DSICK_DIV_MSB 7
`define DSICK_MUX_LSB 8
`define DSICK_MUX_MSB 10
`define DSICK_PLLN_LSB 0
`define DSICK_PLLN_MSB 4
`define DSICK_PLLM_LSB 8
`define DSICK_PLLM_MSB 15
`define DSICK_PLLO_LSB 16
`define DSICK_PLLO_MSB 17
`define DSICK_DROP_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DSICK_ROOT_RST 11'h000
`define DSICK_GROUP_RST 8'h00
`define DSICK_PLLN_RST 5'h1f
`define DSICK_PLLM_RST 8'hc1
`define DSICK_PLLO_RST 2'h0

// ----------------------------------------------------------------
// source selects and code maps
// ----------------------------------------------------------------
`define DSICK_SEL_SYSPLL2 3'h4
`define DSICK_SEL_XTAL 3'h1
`define DSICK_PLLN_TOP 5'h1f
`define DSICK_PLLM_BASE 8'ha0
`define DSICK_BYTE_BITS 3'h7

`endif

// *** src/dsick_clock_tree.v ***
// clock tree of the serial display host: three clock roots, the transmit
// escape group divider, a pll model, byte and lane clocks, and the pixel bridge
// assumes every clock here is a one-cycle enable pulse on sys_clk, so a source
// tick can come at most once per cycle; all inputs are synchronous to sys_clk
`include "dsick_regs.vh"

module dsick_clock_tree #(
    parameter DIVW = 8, // width of root and group divider fields
    parameter PIXW = 24 // width of a pixel word
) (
    input wire sys_clk, // 250 MHz system clock
    input wire rst, // synchronous reset, active high
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    input wire [7:0] srcTick, // source enables, [4] second pll, [1] crystal
    input wire pixValid, // pixel word present
    input wire [PIXW-1:0] pixData, // pixel word
    output reg pixRootTick, // pixel root enable
    output reg escRxTick, // receive escape enable, undivided root
    output reg escTxTick, // transmit escape enable, group divided
    output reg refRootTick, // pll reference enable
    output reg bitTick, // high-speed bit clock enable
    output reg byteTick, // byte clock enable
    output reg laneClk, // clock lane level
    output reg fwdPixTick, // pixel enable forwarded with data
    output reg [PIXW-1:0] fwdPixData, // pixel data forwarded to bridge
    output reg fwdPixValid, // forwarded pixel valid
    output reg [PIXW-1:0] bytePixData, // pixel word in byte domain
    output reg bytePixValid // one byte-tick pulse per moved pixel
);

    // ----------------------------------------------------------------
    // decode helpers for the encoded pll codes
    // ----------------------------------------------------------------
    function [5:0] decN; // 0x1f means divide by one
        input [4:0] code;
        begin
            decN = {1'b0, `DSICK_PLLN_TOP - code} + 6'h01;
        end
    endfunction

    function [7:0] decM; // 0xc1 means multiply by 33
        input [7:0] code;
        begin
            decM = code - `DSICK_PLLM_BASE;
        end
    endfunction

    function [3:0] decO; // 0 means divide by one, power of two steps
        input [1:0] code;
        begin
            decO = 4'h1 << code;
        end
    endfunction

    // ----------------------------------------------------------------
    // software settings
    // ----------------------------------------------------------------
    reg [10:0] rootCfg_q [0:2]; // mux and div of the three roots
    reg [DIVW-1:0] grpDiv_q; // transmit escape group divider
    reg [4:0] pllN_q; // pll predivider code
    reg [7:0] pllM_q; // pll multiplier code
    reg [1:0] pllO_q; // pll output divider code
    reg dropSeen_q; // sticky: a pixel was lost in the bridge

    wire setup = psel & ~penable; // first apb cycle
    wire access = psel & penable & pready; // completing cycle
    wire mapped = (paddr <= `DSICK_STATUS_OFS) && (paddr[1:0] == 2'h0);
    wire wrEn = access & pwrite & ~pslverr; // write takes effect here
    reg dropSet; // bridge loses a pixel this cycle

    // ----------------------------------------------------------------
    // apb slave: no wait states, data and error registered in setup
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= 32'h0000_0000;
            case (paddr)
                `DSICK_PIX_ROOT_OFS: prdata <= {21'h000000, rootCfg_q[0]};
                `DSICK_ESC_ROOT_OFS: prdata <= {21'h000000, rootCfg_q[1]};
                `DSICK_REF_ROOT_OFS: prdata <= {21'h000000, rootCfg_q[2]};
                `DSICK_ESC_GROUP_OFS: prdata <= {{(32-DIVW){1'b0}}, grpDiv_q};
                `DSICK_PLL_OFS: prdata <= {14'h0000, pllO_q, pllM_q, 3'h0, pllN_q};
                `DSICK_STATUS_OFS: prdata <= {31'h00000000, dropSeen_q};
                default: prdata <= 32'h0000_0000; // unmapped reads zero
            endcase
        end else begin
            pready <= 1'b0; // ready only for the access cycle
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register writes; status drop bit is write-one-to-clear
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            rootCfg_q[0] <= `DSICK_ROOT_RST;
            rootCfg_q[1] <= `DSICK_ROOT_RST;
            rootCfg_q[2] <= `DSICK_ROOT_RST;
            grpDiv_q <= `DSICK_GROUP_RST;
            pllN_q <= `DSICK_PLLN_RST;
            pllM_q <= `DSICK_PLLM_RST;
            pllO_q <= `DSICK_PLLO_RST;
            dropSeen_q <= 1'b0;
        end else begin
            if (wrEn) begin
                case (paddr)
                    `DSICK_PIX_ROOT_OFS: rootCfg_q[0] <= pwdata[10:0];
                    `DSICK_ESC_ROOT_OFS: rootCfg_q[1] <= pwdata[10:0];
                    `DSICK_REF_ROOT_OFS: rootCfg_q[2] <= pwdata[10:0];
                    `DSICK_ESC_GROUP_OFS: grpDiv_q <= pwdata[DIVW-1:0];
                    `DSICK_PLL_OFS: begin
                        pllN_q <= pwdata[`DSICK_PLLN_MSB:`DSICK_PLLN_LSB];
                        pllM_q <= pwdata[`DSICK_PLLM_MSB:`DSICK_PLLM_LSB];
                        pllO_q <= pwdata[`DSICK_PLLO_MSB:`DSICK_PLLO_LSB];
                    end
                    default: ; // status and unmapped hold
                endcase
            end
            // set beats clear when both land in one cycle
            if (dropSet)
                dropSeen_q <= 1'b1;
            else if (wrEn && paddr == `DSICK_STATUS_OFS && pwdata[`DSICK_DROP_BIT])
                dropSeen_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // clock roots: 0 pixel, 1 escape, 2 pll reference
    // ----------------------------------------------------------------
    wire [2:0] rootTick; // divided root enables
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gRoot
            reg [DIVW-1:0] cnt_q; // source ticks in this period
            reg [DIVW-1:0] actDiv_q; // divider in force
            reg [2:0] actMux_q; // select in force
            reg tick_q; // root output enable
            // selected source; select 4 is the second system pll and
            // select 1 the crystal, wired by the srcTick bit order
            wire src = srcTick[actMux_q];
            always @(posedge sys_clk) begin
                if (rst) begin
                    cnt_q <= {DIVW{1'b0}};
                    actDiv_q <= {DIVW{1'b0}};
                    actMux_q <= 3'h0;
                    tick_q <= 1'b0;
                end else if (src && cnt_q == actDiv_q) begin
                    // period done: divide by div plus one
                    cnt_q <= {DIVW{1'b0}};
                    tick_q <= 1'b1;
                    // new settings only at a period edge, never mid-pulse
                    actDiv_q <= rootCfg_q[g][`DSICK_DIV_MSB:`DSICK_DIV_LSB];
                    actMux_q <= rootCfg_q[g][`DSICK_MUX_MSB:`DSICK_MUX_LSB];
                end else begin
                    if (src)
                        cnt_q <= cnt_q + 1'b1;
                    tick_q <= 1'b0;
                end
            end
            assign rootTick[g] = tick_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // transmit escape group divider, receive takes the root as is
    // ----------------------------------------------------------------
    reg [DIVW-1:0] grpCnt_q; // escape root ticks counted
    reg [DIVW-1:0] grpAct_q; // group divider in force
    always @(posedge sys_clk) begin
        if (rst) begin
            grpCnt_q <= {DIVW{1'b0}};
            grpAct_q <= {DIVW{1'b0}};
            escTxTick <= 1'b0;
            escRxTick <= 1'b0;
            pixRootTick <= 1'b0;
            refRootTick <= 1'b0;
        end else begin
            escRxTick <= rootTick[1];
            pixRootTick <= rootTick[0];
            refRootTick <= rootTick[2];
            escTxTick <= 1'b0;
            if (rootTick[1]) begin
                if (grpCnt_q == grpAct_q) begin
                    grpCnt_q <= {DIVW{1'b0}};
                    grpAct_q <= grpDiv_q;
                    escTxTick <= 1'b1;
                end else begin
                    grpCnt_q <= grpCnt_q + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pll model: adds M per reference tick, emits one bit tick per
    // N*O; limited to one bit tick per sys_clk cycle
    // ----------------------------------------------------------------
    reg [15:0] pllAcc_q; // phase accumulator
    wire [9:0] pllDen = decN(pllN_q) * decO(pllO_q);
    wire [15:0] accIn = pllAcc_q + (rootTick[2] ? {8'h00, decM(pllM_q)} : 16'h0000);
    wire bitFire = accIn >= {6'h00, pllDen};
    reg [2:0] bitCnt_q; // bit ticks within a byte
    always @(posedge sys_clk) begin
        if (rst) begin
            pllAcc_q <= 16'h0000;
            bitTick <= 1'b0;
            bitCnt_q <= 3'h0;
            byteTick <= 1'b0;
            laneClk <= 1'b0;
        end else begin
            pllAcc_q <= bitFire ? accIn - {6'h00, pllDen} : accIn;
            bitTick <= bitFire;
            byteTick <= bitFire && bitCnt_q == `DSICK_BYTE_BITS;
            if (bitFire) begin
                bitCnt_q <= bitCnt_q + 3'h1;
                laneClk <= ~laneClk;
            end
        end
    end

    // ----------------------------------------------------------------
    // pixel forwarding and pixel-to-byte bridge, one word deep
    // ----------------------------------------------------------------
    reg holdFull_q; // a pixel waits for a byte tick
    always @* begin
        dropSet = rootTick[0] & pixValid & holdFull_q & ~byteTick;
    end
    always @(posedge sys_clk) begin
        if (rst) begin
            fwdPixTick <= 1'b0;
            fwdPixData <= {PIXW{1'b0}};
            fwdPixValid <= 1'b0;
            holdFull_q <= 1'b0;
            bytePixData <= {PIXW{1'b0}};
            bytePixValid <= 1'b0;
        end else begin
            fwdPixTick <= rootTick[0];
            bytePixValid <= 1'b0;
            if (rootTick[0]) begin
                fwdPixData <= pixData;
                fwdPixValid <= pixValid;
            end
            // a too slow byte rate overruns the hold and drops pixels
            if (byteTick && holdFull_q) begin
                bytePixData <= fwdPixData;
                bytePixValid <= 1'b1;
                holdFull_q <= 1'b0;
            end
            if (rootTick[0] && pixValid && (!holdFull_q || byteTick))
                holdFull_q <= 1'b1;
        end
    end

endmodule // dsick_clock_tree

// *** testbench/dsick_checker.sv ***
// port-level timing checks of the clock tree
// assumes the clock tree top module and its synchronous active-high reset
module dsick_checker (
    input wire sys_clk, // system clock
    input wire rst, // sync reset
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire pixRootTick, // pixel root enable
    input wire escRxTick, // rx escape enable
    input wire escTxTick, // tx escape enable
    input wire bitTick, // bit clock enable
    input wire byteTick, // byte clock enable
    input wire laneClk, // clock lane level
    input wire bytePixValid // pixel moved to byte domain
);
    // ----------------------------------------
    // helper: bit ticks modulo eight
    // ----------------------------------------
    reg [2:0] bitCnt_q; // bits seen since last byte boundary
    always @(posedge sys_clk) begin
        if (rst) begin
            bitCnt_q <= 3'h0;
        end else if (bitTick) begin
            bitCnt_q <= bitCnt_q + 3'h1; // wraps on the eighth bit
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    byte_eighth_a: assert property (byteTick == (bitTick && bitCnt_q == 3'h7))
        else $error("byte tick not on eighth bit");
    lane_half_a: assert property ($changed(laneClk) == bitTick)
        else $error("lane clock not toggling per bit");
    tx_with_rx_a: assert property (escTxTick |-> escRxTick)
        else $error("tx escape off the root tick");
    byte_pixel_a: assert property (bytePixValid |-> byteTick || $past(byteTick))
        else $error("pixel moved without byte tick");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !pready && !bitTick && !pixRootTick)
        else $error("outputs active after reset");
endmodule // dsick_checker

bind dsick_clock_tree dsick_checker dsick_checker_inst (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .pixRootTick(pixRootTick), .escRxTick(escRxTick), .escTxTick(escTxTick),
    .bitTick(bitTick), .byteTick(byteTick), .laneClk(laneClk), .bytePixValid(bytePixValid));

// *** testbench/testbench.sv ***
// self-checking bench of the clock tree: apb setup, tick rates, bridge
// assumes source ticks every cycle stand in for the real sources
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdWord;
    logic [7:0] srcTick = 8'h00, srcMask = 8'h00;
    logic pixValid = 1'b0, rdErr, counting = 1'b0;
    logic [23:0] pixData = 24'h000000;
    wire [31:0] prdata;
    wire [23:0] fwdPixData, bytePixData;
    wire pready, pslverr, pixRootTick, escRxTick, escTxTick, refRootTick, bitTick, byteTick;
    wire laneClk, fwdPixTick, fwdPixValid, bytePixValid;
    int miscompares = 0, samples_checked = 0;
    int cnt [0:6]; // windowed tick counts, [6] forwarded pixel ticks
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) srcTick <= srcMask; // steady source pattern
    // tick counters, windowed so periodic patterns give exact totals
    always @(posedge sys_clk) begin
        if (counting) begin
            cnt[0] += pixRootTick;
            cnt[1] += escRxTick;
            cnt[2] += escTxTick;
            cnt[3] += refRootTick;
            cnt[4] += bitTick;
            cnt[5] += byteTick;
            cnt[6] += fwdPixTick;
        end
    end
    dsick_clock_tree dsick_clock_tree_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .srcTick(srcTick), .pixValid(pixValid),
        .pixData(pixData), .pixRootTick(pixRootTick), .escRxTick(escRxTick),
        .escTxTick(escTxTick), .refRootTick(refRootTick), .bitTick(bitTick),
        .byteTick(byteTick), .laneClk(laneClk), .fwdPixTick(fwdPixTick),
        .fwdPixData(fwdPixData), .fwdPixValid(fwdPixValid), .bytePixData(bytePixData),
        .bytePixValid(bytePixValid));
    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check32(32'h0, 32'h1, "apb hang");
        rdWord = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic measure(input int cycles);
        cnt = '{default: 0};
        repeat (400) @(posedge sys_clk); // let settings and pll backlog settle
        counting <= 1'b1;
        repeat (cycles) @(posedge sys_clk);
        counting <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic t_reset_values();
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check32(rdWord, 32'h0, "root reset");
        end
        apb(1'b0, 12'h010, 32'h0);
        check32(rdWord, 32'h0000c11f, "pll codes reset");
        apb(1'b0, 12'h018, 32'h0);
        check32({31'h0, rdErr}, 32'h1, "unmapped error");
        check32(rdWord, 32'h0, "unmapped data");
    endtask
    task automatic t_roots();
        apb(1'b1, 12'h000, 32'h00000409); // second pll, divide by ten
        apb(1'b1, 12'h004, 32'h00000101); // crystal, divide by two
        apb(1'b1, 12'h008, 32'h00000127); // crystal, divide by forty
        apb(1'b1, 12'h00c, 32'h00000001); // tx group halves
        pixData <= 24'h5a3c96;
        pixValid <= 1'b1;
        srcMask <= 8'h13; // byte rate kept above the pixel rate
        measure(3200);
        check32(cnt[0], 32'd320, "pixel root rate");
        check32(cnt[1], 32'd1600, "rx escape rate");
        check32(cnt[2], 32'd800, "tx escape rate");
        check32(cnt[3], 32'd80, "reference rate");
        check32(cnt[4], 32'd2640, "bit rate, m 33");
        check32(cnt[5], 32'd330, "byte rate");
        check32(cnt[6], 32'd320, "forwarded pixel tick rate");
        check32({7'h0, fwdPixValid, fwdPixData}, 32'h015a3c96, "forwarded pixel");
        check32({8'h0, bytePixData}, 32'h005a3c96, "bridged pixel");
    endtask
    task automatic t_pll_div();
        apb(1'b1, 12'h010, 32'h0001c11e); // n 2, o 2, m 33
        apb(1'b0, 12'h010, 32'h0);
        check32(rdWord, 32'h0001c11e, "pll codes readback");
        measure(3200);
        check32(cnt[4], 32'd660, "bit rate over n times o");
        apb(1'b0, 12'h014, 32'h0);
        check32(rdWord, 32'h1, "drop flagged");
        pixValid <= 1'b0;
        apb(1'b1, 12'h014, 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        check32(rdWord, 32'h0, "drop cleared");
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_values();
        t_roots();
        t_pll_div();
        report_and_stop();
    end
    // watchdog, about four times the expected run
    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end
endmodule // testbench
